// [src/ssp_pkg.sv]
// Function
// - Serial clock idles high; the first falling edge starts a transfer.
// - First transmit bit leaves on first falling edge, the rest on later falls.
// - Serial input is sampled on every rising serial clock edge.
// - A transfer is exactly eight bits and ends on the eighth rising edge.
// - Master and slave differ only in where the serial clock comes from.
// - Master clock rate comes from the system clock via fixed rate option.
// - A fixed option picks low or high bit first for both directions.
// - When enabled the shared pins become data out, data in and clock.
// - Input at enable; output driven straight from last shift stage; code latches that stage into the serial_out flop on each falling edge.
// - Port writes to the output pin ignored; pre-enable level sets start state.
// - Clearing enable aborts the transfer, clears the counter, releases pins.
// - In master mode a data register write starts a transfer.
// - Master select is always read/write; clearing it aborts a transfer.
// - Reset clears master select and enable.
// - Done flag is read-only, sets on last rising edge, affects nothing else.
// - Done flag clears by status read then data access; last edge sets it, winning over a clear.
// - Collision sets on data access after first fall and before done sets.
// - Collision clears by status read with done set then data access.
// - Reset clears the done and collision flags.
// - One data register serves both directions and keeps its value over reset.
// - Shared port registers stay usable while enabled; writes may corrupt data.
//
// Purpose: Constants and types of the simple serial port.
// Assumes: Register indices are word indices on a 32-bit bus.
// Notes: Byte address of a register is four times its index.
package ssp_pkg;
  localparam logic [7:0] IDX_CONTROL = 8'h0a;
  localparam logic [7:0] IDX_STATUS = 8'h0b;
  localparam logic [7:0] IDX_DATA = 8'h0c;
  localparam int CTRL_EN_BIT = 6;
  localparam int CTRL_MASTER_BIT = 4;
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_COLL_BIT = 6;
  localparam int BITS_PER_XFER = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_HALF_NS = 500;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam bit LOW_BIT_FIRST_DEFAULT = 1'b0;

  typedef enum logic [1:0] {REG_CONTROL, REG_STATUS, REG_DATA, REG_NONE} ssp_reg_t;

  typedef struct packed {
    logic en;
    logic master_select;
  } ssp_ctrl_t;

  typedef struct packed {
    logic done;
    logic coll;
  } ssp_stat_t;
endpackage

// [src/ssp_serial_port.sv]
// Purpose: Eight-bit three-wire synchronous serial port with an AXI4-Lite register slave.
// Assumes: Master half period of at least eight system clocks; slave clock well below aclk/8.
// Notes: Pin ownership goes back to the general port whenever port_owns_pins is low.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module ssp_serial_port
#(
  parameter int RATE_HALF_CYCLES = ssp_pkg::SCK_HALF_CYCLES,
  parameter bit LOW_BIT_FIRST = ssp_pkg::LOW_BIT_FIRST_DEFAULT
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial pins
  input wire logic serial_in,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic serial_out,
  output logic serial_out_oe,
  // Shared port hookup
  input wire logic gpio_out_level,
  output logic port_owns_pins
);

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  function automatic ssp_pkg::ssp_reg_t decode(input logic [31:0] addr);
    if (addr == {22'h0, ssp_pkg::IDX_CONTROL, 2'h0})
      return ssp_pkg::REG_CONTROL;
    else if (addr == {22'h0, ssp_pkg::IDX_STATUS, 2'h0})
      return ssp_pkg::REG_STATUS;
    else if (addr == {22'h0, ssp_pkg::IDX_DATA, 2'h0})
      return ssp_pkg::REG_DATA;
    else
      return ssp_pkg::REG_NONE;
  endfunction

  ssp_pkg::ssp_ctrl_t ctrl_reg;
  ssp_pkg::ssp_stat_t stat_reg;
  logic [7:0] shift_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic arm_done_reg;
  logic arm_coll_reg;
  logic xfer_reg;
  logic [3:0] bit_cnt_reg;
  logic m_run_reg;
  logic sck_reg;
  logic [15:0] div_reg;
  logic [2:0] sck_sync_reg;
  logic sck_state_reg;
  logic [2:0] si_sync_reg;
  logic si_state_reg;
  logic wr_fire;
  logic rd_fire;
  ssp_pkg::ssp_reg_t wr_sel;
  ssp_pkg::ssp_reg_t rd_sel;
  logic wr_ctrl;
  logic wr_data;
  logic rd_stat;
  logic data_access;
  logic abort;
  logic m_tick;
  logic s_chg;
  logic fall_ev;
  logic rise_ev;
  logic last_rise;
  logic [7:0] ctrl_wbyte;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid;
  assign rd_fire = arvalid && arready;
  assign wr_sel = decode(aw_addr_reg);
  assign rd_sel = decode(araddr);
  assign wr_ctrl = wr_fire && (wr_sel == ssp_pkg::REG_CONTROL) && w_strb_reg[0];
  assign wr_data = wr_fire && (wr_sel == ssp_pkg::REG_DATA) && w_strb_reg[0];
  assign rd_stat = rd_fire && (rd_sel == ssp_pkg::REG_STATUS);
  assign data_access = wr_data || (rd_fire && (rd_sel == ssp_pkg::REG_DATA));
  assign ctrl_wbyte = w_data_reg[7:0];

  // ---------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      awready <= 1'b0;
      aw_addr_reg <= 32'h0;
    end
    else if (awvalid && awready)
    begin
      aw_have_reg <= 1'b1;
      awready <= 1'b0;
      aw_addr_reg <= awaddr;
    end
    else if (wr_fire)
    begin
      aw_have_reg <= 1'b0;
      awready <= 1'b1;
    end
    else
      awready <= !aw_have_reg;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_reg <= 1'b0;
      wready <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_have_reg <= 1'b1;
      wready <= 1'b0;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
    else if (wr_fire)
    begin
      w_have_reg <= 1'b0;
      wready <= 1'b1;
    end
    else
      wready <= !w_have_reg;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= ssp_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == ssp_pkg::REG_NONE) ? ssp_pkg::RESP_SLVERR : ssp_pkg::RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= ssp_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= ssp_pkg::RESP_OKAY;
      rdata <= 32'h0;
      case (rd_sel)
        ssp_pkg::REG_CONTROL:
        begin
          rdata[ssp_pkg::CTRL_EN_BIT] <= ctrl_reg.en;
          rdata[ssp_pkg::CTRL_MASTER_BIT] <= ctrl_reg.master_select;
        end
        ssp_pkg::REG_STATUS:
        begin
          rdata[ssp_pkg::STAT_DONE_BIT] <= stat_reg.done;
          rdata[ssp_pkg::STAT_COLL_BIT] <= stat_reg.coll;
        end
        ssp_pkg::REG_DATA:
          rdata[7:0] <= shift_reg;
        default:
          rresp <= ssp_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
    else
      arready <= !rvalid;
  end

  // ---------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------
  // Master select stays writable whether or not the port is enabled.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg.en <= ssp_pkg::CTRL_RESET[ssp_pkg::CTRL_EN_BIT];
      ctrl_reg.master_select <= ssp_pkg::CTRL_RESET[ssp_pkg::CTRL_MASTER_BIT];
    end
    else if (wr_ctrl)
    begin
      ctrl_reg.en <= ctrl_wbyte[ssp_pkg::CTRL_EN_BIT];
      ctrl_reg.master_select <= ctrl_wbyte[ssp_pkg::CTRL_MASTER_BIT];
    end
  end
  assign abort = !ctrl_reg.en ||
    (wr_ctrl && ctrl_reg.master_select && !ctrl_wbyte[ssp_pkg::CTRL_MASTER_BIT]);

  // ---------------------------------------------------------------------
  // Pin synchronisers and slave clock edges
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_sync_reg <= 3'h7;
      sck_state_reg <= 1'b1;
      si_sync_reg <= 3'h0;
      si_state_reg <= 1'b0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      si_sync_reg <= {si_sync_reg[1:0], serial_in};
      if (sck_sync_reg[1] == sck_sync_reg[2])
        sck_state_reg <= sck_sync_reg[2];
      if (si_sync_reg[1] == si_sync_reg[2])
        si_state_reg <= si_sync_reg[2];
    end
  end
  assign s_chg = (sck_sync_reg[1] == sck_sync_reg[2]) && (sck_sync_reg[2] != sck_state_reg);

  // ---------------------------------------------------------------------
  // Master clock generator
  // ---------------------------------------------------------------------
  assign m_tick = m_run_reg && (div_reg == 16'(RATE_HALF_CYCLES - 1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort || !ctrl_reg.master_select)
    begin
      m_run_reg <= 1'b0;
      sck_reg <= 1'b1;
      div_reg <= 16'h0;
    end
    else if (wr_data && !m_run_reg && !xfer_reg)
    begin
      m_run_reg <= 1'b1;
      div_reg <= 16'h0;
    end
    else if (m_run_reg)
    begin
      if (m_tick)
      begin
        div_reg <= 16'h0;
        sck_reg <= !sck_reg;
        if (last_rise)
          m_run_reg <= 1'b0;
      end
      else
        div_reg <= div_reg + 16'h1;
    end
  end
  // Both modes feed the same shift engine; only the clock source differs.
  assign fall_ev = ctrl_reg.en && (ctrl_reg.master_select ? (m_tick && sck_reg) : (s_chg && !sck_sync_reg[2]));
  assign rise_ev = ctrl_reg.en && (ctrl_reg.master_select ? (m_tick && !sck_reg) : (s_chg && sck_sync_reg[2]));
  assign last_rise = rise_ev && xfer_reg && (bit_cnt_reg == 4'(ssp_pkg::BITS_PER_XFER - 1));
  // ---------------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort)
    begin
      xfer_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end
    else if (fall_ev && !xfer_reg)
    begin
      xfer_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
    end
    else if (rise_ev && xfer_reg)
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (last_rise)
        xfer_reg <= 1'b0;
    end
  end

  // The data register is left alone by reset.
  always_ff @(posedge aclk)
  begin
    if (wr_data)
      shift_reg <= w_data_reg[7:0];
    else if (rise_ev && xfer_reg)
    begin
      if (LOW_BIT_FIRST)
        shift_reg <= {si_state_reg, shift_reg[7:1]};
      else
        shift_reg <= {shift_reg[6:0], si_state_reg};
    end
  end

  // The output follows the port level while disabled and holds it until the first falling edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_out <= 1'b1;
    else if (!ctrl_reg.en)
      serial_out <= gpio_out_level;
    else if (fall_ev)
      serial_out <= LOW_BIT_FIRST ? shift_reg[0] : shift_reg[7];
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_out_oe <= 1'b0;
      sck_oe <= 1'b0;
      sck_out <= 1'b1;
      port_owns_pins <= 1'b0;
    end
    else
    begin
      serial_out_oe <= ctrl_reg.en;
      sck_oe <= ctrl_reg.en && ctrl_reg.master_select;
      sck_out <= sck_reg;
      port_owns_pins <= ctrl_reg.en;
    end
  end

  // ---------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arm_done_reg <= 1'b0;
      arm_coll_reg <= 1'b0;
    end
    else if (rd_stat)
    begin
      arm_done_reg <= 1'b1;
      arm_coll_reg <= stat_reg.done;
    end
    else if (data_access)
    begin
      arm_done_reg <= 1'b0;
      arm_coll_reg <= 1'b0;
    end
  end

  // A setting event always wins over a clear in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_reg.done <= 1'b0;
      stat_reg.coll <= 1'b0;
    end
    else
    begin
      if (last_rise)
        stat_reg.done <= 1'b1;
      else if (data_access && arm_done_reg)
        stat_reg.done <= 1'b0;
      if (data_access && xfer_reg)
        stat_reg.coll <= 1'b1;
      else if (data_access && arm_coll_reg)
        stat_reg.coll <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [verification/ssp_serial_port_asserts.sv]
// Purpose: Port-level checks of the serial port.
// Assumes: Master half period of several clocks.
// Notes: Bound from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module ssp_serial_port_asserts
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Pins
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic port_owns_pins
);
  logic q;
  logic [3:0] c;
  // Counts driven clock rises since the last completed byte.
  always_ff @(posedge aclk)
  begin
    q <= sck_out;
    if (!aresetn || !sck_oe)
      c <= 4'h0;
    else if (sck_out && !q)
      c <= c + 4'h1;
    else if (!sck_out && q && c == 4'h8)
      c <= 4'h0;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_take |-> ##2 bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_OUT_OE: assert property (serial_out_oe == port_owns_pins)
    else $error("data output enable wrong");
  AST_CLK_OE: assert property (sck_oe |-> port_owns_pins)
    else $error("clock driven while disabled");
  AST_FALL_DRIVEN: assert property ($fell(sck_out) |-> sck_oe)
    else $error("clock fell while not driven");
  AST_IDLE_HIGH: assert property ($rose(sck_oe) |-> sck_out)
    else $error("clock not idle high");
  AST_RISE_HOLD: assert property (sck_oe && $rose(sck_out) |-> $stable(serial_out))
    else $error("data moved on a rise");
  AST_EIGHT: assert property (c <= 4'h8)
    else $error("more than eight clock rises");
  AST_RESET_OFF: assert property ($rose(aresetn) |-> !port_owns_pins && !sck_oe && sck_out)
    else $error("port active after reset");
endmodule
`default_nettype wire

// [verification/ssp_far_end.sv]
// Purpose: Far-end serial device model.
// Assumes: High bit first; clock idles high.
// Notes: Between frames the data line holds for eight cycles after the last rise, then toggles each cycle.
`timescale 1ns/1ns
`default_nettype none
module ssp_far_end
#(
  parameter int HALF = 10
)
(
  // System
  input wire logic aclk,
  // Bench control
  input wire logic load,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  // Link
  input wire logic sck_line,
  input wire logic serial_out,
  output logic serial_in,
  output logic sck_drv
);
  logic p = 1'b1;
  logic busy = 1'b0;
  logic [3:0] rises = 4'h0;
  logic [3:0] hold = 4'h0;
  logic [7:0] sh = 8'h00;
  int t = 0;
  int k = 0;
  initial serial_in = 1'b0;
  initial sck_drv = 1'b1;
  initial rx_byte = 8'h00;
  always @(posedge aclk)
  begin
    p <= sck_line;
    if (load)
    begin
      sh <= tx_byte;
      busy <= 1'b0;
      rises <= 4'h0;
      hold <= 4'h0;
    end
    else if (p && !sck_line)
    begin
      busy <= 1'b1;
      serial_in <= sh[7];
      sh <= {sh[6:0], 1'b0};
    end
    else if (!p && sck_line && busy)
    begin
      rx_byte <= {rx_byte[6:0], serial_out};
      rises <= rises + 4'h1;
    end
    else if (rises == 4'h8 && hold < 4'h8)
      hold <= hold + 4'h1;
    else if (!busy || hold == 4'h8)
      serial_in <= ~serial_in;
  end
  // Clock source for slave mode.
  always @(posedge aclk)
  begin
    if (go)
    begin
      k <= 16;
      t <= HALF;
    end
    else if (k != 0)
    begin
      if (t == 1)
      begin
        sck_drv <= ~sck_drv;
        k <= k - 1;
        t <= HALF;
      end
      else
        t <= t - 1;
    end
  end
endmodule
`default_nettype wire

// [verification/tb_ssp_serial_port.sv]
// Purpose: Self-checking bench of the serial port.
// Assumes: Master half period of eight clocks.
// Notes: Bus accesses go through one master task.
`timescale 1ns/1ns
`default_nettype none
module tb_ssp_serial_port;
  typedef struct {bit w; logic [7:0] i; logic [7:0] d; logic [7:0] q; logic [1:0] r;} ssp_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  logic sck_out, sck_oe, serial_out, serial_out_oe, port_owns_pins, gpio, serial_in, sck_drv, sck_line;
  logic load, go;
  logic [7:0] tx, rx;
  int fail_count = 0;
  int checks_done = 0;
  ssp_row_t rows[6];
  logic [31:0] q;
  logic [1:0] r;
  always #4 aclk = ~aclk;
  assign sck_line = sck_oe ? sck_out : sck_drv;
  ssp_serial_port #(.RATE_HALF_CYCLES(8)) ssp_serial_port_inst (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .serial_in(serial_in),
    .sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .gpio_out_level(gpio), .port_owns_pins(port_owns_pins));
  ssp_far_end ssp_far_end_inst (.aclk(aclk), .load(load), .go(go), .tx_byte(tx), .rx_byte(rx),
    .sck_line(sck_line), .serial_out(serial_out), .serial_in(serial_in), .sck_drv(sck_drv));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input bit w, input logic [7:0] i, input logic [7:0] d);
    @(posedge aclk);
    if (w)
    begin
      awvalid <= 1'b1;
      awaddr <= {22'h0, i, 2'h0};
      wvalid <= 1'b1;
      wdata <= {24'h0, d};
      bready <= 1'b1;
    end
    else
    begin
      arvalid <= 1'b1;
      araddr <= {22'h0, i, 2'h0};
      rready <= 1'b1;
    end
    for (int k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (w && bvalid === 1'b1)
      begin
        bready <= 1'b0;
        r = bresp;
        return;
      end
      if (!w && rvalid === 1'b1)
      begin
        rready <= 1'b0;
        q = rdata;
        r = rresp;
        return;
      end
    end
    fail_count++;
    complete_run();
  endtask
  task automatic rchk(input string n, input logic [7:0] i, input logic [7:0] e);
    acc(1'b0, i, 8'h00);
    chk(n, {24'h0, e}, q);
  endtask
  task automatic ld(input logic [7:0] b);
    tx <= b;
    load <= 1'b1;
    @(posedge aclk);
    load <= 1'b0;
  endtask
  task automatic wait_done();
    for (int k = 0; k < 80; k++)
    begin
      acc(1'b0, ssp_pkg::IDX_STATUS, 8'h00);
      if (q[ssp_pkg::STAT_DONE_BIT] === 1'b1)
      begin
        // In master mode the far end takes in the last bit two clocks after the flag sets.
        repeat (2) @(posedge aclk);
        return;
      end
    end
    fail_count++;
    complete_run();
  endtask
  task automatic wait_fall();
    for (int k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (sck_out === 1'b0)
        return;
    end
    fail_count++;
    complete_run();
  endtask
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, gpio, load, go} = '0;
    {awaddr, wdata, araddr} = '0;
    tx = 8'h00;
    rows = '{'{1, 8'h0a, 8'h10, 8'h00, 2'h0}, '{0, 8'h0a, 8'h00, 8'h10, 2'h0}, '{1, 8'h0f, 8'h5a, 8'h00, 2'h2},
      '{0, 8'h0f, 8'h00, 8'h00, 2'h2}, '{1, 8'h0a, 8'h00, 8'h00, 2'h0}, '{0, 8'h0a, 8'h00, 8'h00, 2'h0}};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("pins", 4'b0010, {port_owns_pins, sck_oe, sck_out, serial_out_oe});
    rchk("status", ssp_pkg::IDX_STATUS, 8'h00);
    foreach (rows[n])
    begin
      acc(rows[n].w, rows[n].i, rows[n].d);
      chk("resp", rows[n].r, r);
      if (!rows[n].w)
        chk("rdata", {24'h0, rows[n].q}, q);
    end
    $display("register table done");
    gpio <= 1'b1;
    acc(1'b1, ssp_pkg::IDX_CONTROL, 8'h50);
    @(posedge aclk);
    chk("enabled", 4'b1111, {port_owns_pins, sck_oe, serial_out_oe, serial_out});
    ld(8'ha5);
    acc(1'b1, ssp_pkg::IDX_DATA, 8'h3c);
    wait_done();
    chk("sent", 8'h3c, rx);
    rchk("received", ssp_pkg::IDX_DATA, 8'ha5);
    rchk("cleared", ssp_pkg::IDX_STATUS, 8'h00);
    ld(8'h81);
    acc(1'b1, ssp_pkg::IDX_DATA, 8'h7e);
    wait_fall();
    acc(1'b0, ssp_pkg::IDX_DATA, 8'h00);
    wait_done();
    rchk("collision", ssp_pkg::IDX_STATUS, 8'hc0);
    acc(1'b0, ssp_pkg::IDX_DATA, 8'h00);
    rchk("coll clear", ssp_pkg::IDX_STATUS, 8'h00);
    $display("master transfers done");
    ld(8'h11);
    acc(1'b1, ssp_pkg::IDX_DATA, 8'h22);
    wait_fall();
    acc(1'b1, ssp_pkg::IDX_CONTROL, 8'h00);
    @(posedge aclk);
    chk("released", 3'b000, {port_owns_pins, sck_oe, serial_out_oe});
    repeat (120) @(posedge aclk);
    rchk("no done", ssp_pkg::IDX_STATUS, 8'h00);
    $display("abort done");
    acc(1'b1, ssp_pkg::IDX_CONTROL, 8'h40);
    ld(8'hc3);
    acc(1'b1, ssp_pkg::IDX_DATA, 8'h5a);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wait_done();
    chk("slave sent", 9'h05a, {sck_oe, rx});
    rchk("slave got", ssp_pkg::IDX_DATA, 8'hc3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("ctrl reset", ssp_pkg::IDX_CONTROL, 8'h00);
    rchk("data kept", ssp_pkg::IDX_DATA, 8'hc3);
    $display("slave and reset done");
    complete_run();
  end
endmodule
bind ssp_serial_port ssp_serial_port_asserts ssp_serial_port_asserts_inst (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .sck_out(sck_out), .sck_oe(sck_oe), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .port_owns_pins(port_owns_pins));
`default_nettype wire
